// file: logic/cmc_mode_ctrl.sv
// operating-mode controller: mode requests, sleep and wake, bus gating, acceptance
`timescale 1ns/1ns
// What this block does
// - mode request field is control bits 7:5
// - mode status field shows entered mode
// - mode change waits for pending transmissions
// - top request bit asks configuration mode
// - all-zero request returns to normal mode
// - protected writes ignored outside configuration mode
// - no configuration entry during bus frame
// - configuration: silent, counters cleared, pins released
// - request 001 sleeps, clock stops when idle
// - sleep keeps interrupt flags and counters
// - busy sleep waits eleven recessive bits
// - status 001 confirms sleep entry
// - falling bus edge sets wake flag
// - wake restores previous mode, drops frame
// - transmit pin recessive while sleeping
// - normal and loopback transmit, only normal acknowledges
// - listen-only receives all, drives nothing
// - listen-only holds error counters reset
// - loopback routes internally, ignores acknowledge
// - loopback releases transmit pin to port
// - filters apply, zero mask passes all
// - receive mode 11 stores errored frames
// - reset starts legacy mode, six filters
// - frames stored only on filter match
module cmc_mode_ctrl
    import cmc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    // module control register write
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlWdata,
    output logic [2:0] modeRequest,
    output logic [2:0] modeStatus,
    output logic configStatusBit,
    // protocol engine status
    input wire logic txPending,
    input wire logic busActive,
    input wire logic bitTick,
    input wire logic rxBit,
    input wire logic engineTxLevel,
    // protected configuration writes
    input wire logic cfgWrite,
    input wire logic [3:0] cfgAddr,
    input wire logic [10:0] cfgData,
    input wire logic timingWrite,
    output logic timingWriteEn,
    output logic [1:0] funcMode,
    // wake-up
    input wire logic wakeupDisable,
    input wire logic wakeupIrqEnable,
    input wire logic wakeupFlagClear,
    output logic wakeupFlag,
    output logic wakeIrq,
    // mode-driven gating of the protocol engine
    output logic clockEnable,
    output logic txEnable,
    output logic rxEnable,
    output logic ackEnable,
    output logic errFrameEnable,
    output logic errCountClear,
    output logic errCountHold,
    output logic loopbackRoute,
    output logic rxPinGpio,
    output logic txPinGpio,
    output logic busTransmitPin,
    // frames completed in the assembly buffer
    input wire logic frameDone,
    input wire logic frameError,
    input wire logic [10:0] frameId,
    input wire logic [1:0] rxModeZero,
    input wire logic [1:0] rxModeOne,
    output logic storeZero,
    output logic storeOne
);
    // all state lives in one packed struct: r_next is built by a single
    // combinational process and r_reg is its registered copy. this keeps
    // every field on one reset and one clock, and lets a new field be added
    // without touching the sequencer's structure.
    cmc_regs_t r_reg;
    cmc_regs_t r_next;

    // identifier passes when every masked bit equals the filter
    function automatic logic idMatch(
        input logic [10:0] id,
        input logic [10:0] filt,
        input logic [10:0] mask
    );
        idMatch = ((id ^ filt) & mask) == ID_RESET;
    endfunction : idMatch

    logic isConfig;
    logic isSleep;
    logic isNormal;
    logic isListen;
    logic isLoop;
    logic hitZero;
    logic hitOne;
    logic okZero;
    logic okOne;
    logic wakeEdge;

    // mode decodes used by gating and the next-state logic.
    // they read the entered mode, never the request, so no gating output
    // moves before the status field does: software that polls the status
    // sees the engine already reconfigured for the mode it reports.
    assign isConfig = r_reg.mode == MODE_CONFIG;
    assign isSleep = r_reg.mode == MODE_SLEEP;
    assign isNormal = r_reg.mode == MODE_NORMAL;
    assign isListen = r_reg.mode == MODE_LISTEN;
    assign isLoop = r_reg.mode == MODE_LOOPBACK;

    // acceptance: two filters on mask zero, four on mask one.
    // an all-zero mask compares no bit, so every identifier passes; this is
    // the usual setting for bus monitoring in listen-only or loopback.
    // only the standard eleven-bit identifier is compared here.
    always_comb begin
        hitZero = 1'b0;
        hitOne = 1'b0;
        for (int i = 0; i < NUM_FILT; i++) begin
            if (i < FILT_BUF0) begin
                hitZero = hitZero | idMatch(frameId, r_reg.filter[i], r_reg.mask[0]);
            end else begin
                hitOne = hitOne | idMatch(frameId, r_reg.filter[i], r_reg.mask[1]);
            end
        end
    end

    // an errored frame is kept only by error recognition or listen-only
    assign okZero = !frameError || rxModeZero == RXMODE_ERRREC || isListen;
    assign okOne = !frameError || rxModeOne == RXMODE_ERRREC || isListen;
    // recessive-to-dominant edge on the receive pin.
    // the previous level resets to recessive, the idle level of the bus,
    // so leaving reset never looks like a wake edge.
    assign wakeEdge = r_reg.rxPrev && !rxBit;

    // next-state process: request capture, idle detection, mode sequencing,
    // wake handling, protected writes and frame storage, in that order.
    // later statements deliberately override earlier ones: a wake edge wins
    // over a sequencer decision made in the same cycle.
    always_comb begin
        r_next = r_reg;
        r_next.rxPrev = rxBit;
        r_next.storeZero = 1'b0;
        r_next.storeOne = 1'b0;
        // software request, bits 7:5 of the control register
        if (ctrlWrite) begin
            r_next.req = ctrlWdata[REQ_MSB:REQ_LSB];
        end
        // idle detector counts recessive bits, saturating.
        // any dominant bit restarts the count, so only an unbroken run of
        // recessive bits marks the bus idle. with no frame on the bus the
        // count is held at zero and the busy flag alone decides.
        if (busActive) begin
            if (bitTick) begin
                if (!rxBit) begin
                    r_next.idleCnt = 4'h0;
                end else if (r_reg.idleCnt != IDLE_BITS) begin
                    r_next.idleCnt = r_reg.idleCnt + 4'h1;
                end
            end
        end else begin
            r_next.idleCnt = 4'h0;
        end
        // mode change sequencer.
        // a pending transmission freezes every change but a wake, so software must
        // poll the status field before it relies on the new mode.
        // configuration is also refused while a frame is on the bus, and
        // sleep waits for an idle bus in its own state.
        case (r_reg.state)
            ST_RUN: begin
                if (r_reg.req != r_reg.mode && !txPending) begin
                    if (r_reg.req[CFG_BIT]) begin
                        if (!busActive) begin
                            r_next.mode = MODE_CONFIG;
                        end
                    end else if (r_reg.req == MODE_SLEEP) begin
                        if (busActive) begin
                            r_next.state = ST_WAIT_IDLE;
                            r_next.idleCnt = 4'h0;
                        end else begin
                            r_next.prev = r_reg.mode;
                            r_next.mode = MODE_SLEEP;
                        end
                    end else begin
                        r_next.mode = r_reg.req;
                    end
                end
            end
            ST_WAIT_IDLE: begin
                if (r_reg.req != MODE_SLEEP) begin
                    r_next.state = ST_RUN;
                end else if ((r_reg.idleCnt == IDLE_BITS || !busActive) && !txPending) begin
                    r_next.state = ST_RUN;
                    r_next.prev = r_reg.mode;
                    r_next.mode = MODE_SLEEP;
                end
            end
            default: begin
                r_next.state = ST_RUN;
            end
        endcase
        // wake on bus activity restores the mode held before sleep.
        // the request is rewritten too, otherwise the old sleep request
        // would put the module straight back to sleep. the frame that woke
        // the module is lost; firmware has to ask for a retransmission.
        if (isSleep && wakeEdge && !wakeupDisable) begin
            r_next.mode = r_reg.prev;
            r_next.req = r_reg.prev;
            r_next.dropFrame = 1'b1;
        end
        // flag set wins over a clear in the same cycle
        r_next.wakeFlag = (isSleep && wakeEdge && !wakeupDisable)
            || (r_reg.wakeFlag && !wakeupFlagClear);
        // protected registers accept writes only in configuration mode.
        // writes elsewhere are dropped without any error indication, which
        // keeps a stray write from changing filters while the module is
        // online; unused addresses are ignored as well.
        if (cfgWrite && isConfig) begin
            if (cfgAddr == CFG_MASK0 || cfgAddr == CFG_MASK1) begin
                r_next.mask[cfgAddr[0]] = cfgData;
            end else if (cfgAddr >= CFG_FILT0 && cfgAddr < CFG_FILT0 + 4'h6) begin
                r_next.filter[3'(cfgAddr - CFG_FILT0)] = cfgData;
            end else if (cfgAddr == CFG_FUNC) begin
                r_next.funcMode = cfgData[1:0];
            end
        end
        // assembled frame moves to a buffer only on a match, buffer zero first.
        // a hit on buffer zero that is refused for an error does not fall
        // through to buffer one: the frame is simply not stored. the first
        // frame after a wake is discarded whatever its identifier.
        if (frameDone) begin
            r_next.dropFrame = 1'b0;
            if (rxEnable && !r_reg.dropFrame) begin
                if (hitZero) begin
                    r_next.storeZero = okZero;
                end else if (hitOne) begin
                    r_next.storeOne = okOne;
                end
            end
        end
    end

    // single state register; reset lands in configuration, legacy mode.
    // starting in configuration lets software load masks and filters
    // before the module ever joins the bus. the reset branch assigns
    // constants only.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg.state <= ST_RUN;
            r_reg.mode <= MODE_RESET;
            r_reg.req <= MODE_RESET;
            r_reg.prev <= MODE_NORMAL;
            r_reg.idleCnt <= 4'h0;
            r_reg.wakeFlag <= 1'b0;
            r_reg.rxPrev <= 1'b1;
            r_reg.dropFrame <= 1'b0;
            r_reg.funcMode <= FUNC_LEGACY;
            r_reg.mask <= '0;
            r_reg.filter <= '0;
            r_reg.storeZero <= 1'b0;
            r_reg.storeOne <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    // status and configuration views.
    // the request field shows the last software request or the mode a wake restored, the status
    // field what was actually entered; the two differ while a change is
    // deferred. the wake interrupt is the flag gated by its enable.
    assign modeRequest = r_reg.req;
    assign modeStatus = r_reg.mode;
    assign configStatusBit = r_reg.mode[CFG_BIT];
    assign funcMode = r_reg.funcMode;
    assign timingWriteEn = timingWrite && isConfig;
    assign wakeupFlag = r_reg.wakeFlag;
    assign wakeIrq = r_reg.wakeFlag && wakeupIrqEnable;
    assign storeZero = r_reg.storeZero;
    assign storeOne = r_reg.storeOne;

    // the clock keeps running in sleep until the idle wait is over.
    // sleep is only entered once the bus is idle, so gating on the entered
    // mode is enough; the wake edge detector runs on the host clock and
    // stays alive while the engine clock is stopped.
    assign clockEnable = !isSleep;
    // normal and loopback modes transmit, only normal acknowledges; listen-only only listens
    assign txEnable = isNormal || isLoop;
    assign ackEnable = isNormal;
    assign errFrameEnable = isNormal;
    assign rxEnable = isNormal || isListen || isLoop;
    assign loopbackRoute = isLoop;
    // counters cleared in configuration and listen-only, frozen in sleep.
    // interrupt flags are never touched by a mode change.
    assign errCountClear = isConfig || isListen;
    assign errCountHold = isSleep;
    assign rxPinGpio = isConfig;
    assign txPinGpio = isConfig || isLoop;
    // recessive unless normal mode drives the engine's level
    assign busTransmitPin = isNormal ? engineTxLevel : 1'b1;
endmodule : cmc_mode_ctrl

// file: shared/cmc_pkg.sv
// constants and types shared by the operating-mode controller
package cmc_pkg;
    // mode request / mode status codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SLEEP = 3'h1;
    localparam logic [2:0] MODE_LOOPBACK = 3'h2;
    localparam logic [2:0] MODE_LISTEN = 3'h3;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    // reset state: configuration mode, as after any reset
    localparam logic [2:0] MODE_RESET = MODE_CONFIG;
    // module control register field positions
    localparam int REQ_MSB = 7;
    localparam int REQ_LSB = 5;
    localparam int CFG_BIT = 2;
    // receive buffer control: receive mode field value for error recognition
    localparam logic [1:0] RXMODE_ERRREC = 2'h3;
    // consecutive recessive bits that mark an idle bus
    localparam logic [3:0] IDLE_BITS = 4'hb;
    // functional modes; legacy is the reset default
    localparam logic [1:0] FUNC_LEGACY = 2'h0;
    // resources of the legacy functional mode
    localparam int NUM_TX_BUF = 3;
    localparam int NUM_RX_BUF = 2;
    localparam int NUM_FILT = 6;
    localparam int FILT_BUF0 = 2;
    // protected configuration addresses
    localparam logic [3:0] CFG_MASK0 = 4'h0;
    localparam logic [3:0] CFG_MASK1 = 4'h1;
    localparam logic [3:0] CFG_FILT0 = 4'h2;
    localparam logic [3:0] CFG_FUNC = 4'h8;
    localparam int ID_W = 11;
    localparam logic [10:0] ID_RESET = 11'h000;
    typedef enum logic [1:0] {ST_RUN, ST_WAIT_IDLE} cmc_state_t;
    typedef struct packed {
        cmc_state_t state;
        logic [2:0] mode;
        logic [2:0] req;
        logic [2:0] prev;
        logic [3:0] idleCnt;
        logic wakeFlag;
        logic rxPrev;
        logic dropFrame;
        logic [1:0] funcMode;
        logic [1:0][10:0] mask;
        logic [5:0][10:0] filter;
        logic storeZero;
        logic storeOne;
    } cmc_regs_t;
endpackage : cmc_pkg

// file: tb/cmc_mode_chk.sv
// port assertions for the operating-mode controller
`timescale 1ns/1ns
module cmc_mode_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlWdata,
    input wire logic [2:0] modeRequest,
    input wire logic [2:0] modeStatus,
    input wire logic configStatusBit,
    input wire logic txPending,
    input wire logic busActive,
    input wire logic engineTxLevel,
    input wire logic busTransmitPin,
    input wire logic txEnable,
    input wire logic rxEnable,
    input wire logic ackEnable,
    input wire logic errFrameEnable,
    input wire logic errCountClear,
    input wire logic clockEnable,
    input wire logic txPinGpio,
    input wire logic loopbackRoute,
    input wire logic timingWrite,
    input wire logic timingWriteEn,
    input wire logic wakeupFlag,
    input wire logic wakeupIrqEnable,
    input wire logic wakeIrq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [2:0] reqCode;
    // the request field holds the written bits as they are
    assign reqCode = ctrlWdata[7:5];
    req_latch_a: assert property (ctrlWrite |=> modeRequest == $past(reqCode))
        else $error("request field not latched");
    status_bit_a: assert property (configStatusBit == (modeStatus == 3'h4))
        else $error("config status bit wrong");
    pend_hold_a: assert property (txPending && modeStatus != 3'h1 |=> $stable(modeStatus))
        else $error("mode changed with transmission pending");
    cfg_busy_a: assert property (busActive && modeStatus != 3'h4 |=> modeStatus != 3'h4)
        else $error("configuration entered during frame");
    cfg_quiet_a: assert property (modeStatus == 3'h4 |-> errCountClear && !txEnable
        && !rxEnable && txPinGpio)
        else $error("configuration mode not silent");
    sleep_pin_a: assert property (modeStatus == 3'h1 |-> busTransmitPin && !txEnable
        && !clockEnable)
        else $error("sleep not quiet");
    tx_pin_a: assert property (busTransmitPin == (modeStatus == 3'h0 ? engineTxLevel : 1'b1))
        else $error("transmit pin driven outside normal mode");
    listen_quiet_a: assert property (modeStatus == 3'h3 |-> !ackEnable && !errFrameEnable
        && errCountClear)
        else $error("listen mode not silent");
    loop_pin_a: assert property (modeStatus == 3'h2 |-> txPinGpio && loopbackRoute)
        else $error("loopback pin not released");
    timing_lock_a: assert property (timingWriteEn == (timingWrite && modeStatus == 3'h4))
        else $error("timing write not locked");
    wake_irq_a: assert property (wakeIrq == (wakeupFlag && wakeupIrqEnable))
        else $error("wake interrupt wrong");
    wake_exit_a: assert property ($rose(wakeupFlag) |-> modeStatus != 3'h1)
        else $error("wake left module asleep");
endmodule : cmc_mode_chk
bind cmc_mode_ctrl cmc_mode_chk i_chk (.*);

// file: tb/cmc_bus_node.sv
// far-side node: sends one sixteen-bit frame per start pulse
`timescale 1ns/1ns
module cmc_bus_node (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic startFrame,
    output logic busActive,
    output logic bitTick,
    output logic rxBit
);
    logic [1:0] divReg;
    logic [4:0] bitsLeft;
    // bit time of four clocks keeps frames short
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            divReg <= 2'h0;
            bitTick <= 1'b0;
            bitsLeft <= 5'h00;
        end else begin
            divReg <= divReg + 2'h1;
            bitTick <= (divReg == 2'h3);
            if (startFrame)
                bitsLeft <= 5'h10;
            else if (bitTick && bitsLeft != 5'h00)
                bitsLeft <= bitsLeft - 5'h01;
        end
    end
    assign busActive = (bitsLeft != 5'h00);
    // frame opens dominant, idle bus stays recessive
    assign rxBit = busActive ? bitsLeft[0] : 1'b1;
endmodule : cmc_bus_node

// file: tb/testbench.sv
// self-checking bench for the operating-mode controller
`timescale 1ns/1ns
module testbench import cmc_pkg::*;;
    logic mclk, reset_n, ctrlWrite, txPending, engineTxLevel, cfgWrite, timingWrite;
    logic wakeupDisable, wakeupIrqEnable, wakeupFlagClear, frameDone, frameError, startFrame;
    logic [7:0] ctrlWdata;
    logic [3:0] cfgAddr;
    logic [10:0] cfgData, frameId;
    logic [1:0] rxModeZero, rxModeOne, funcMode;
    logic [2:0] modeRequest, modeStatus;
    logic configStatusBit, timingWriteEn, wakeupFlag, wakeIrq, clockEnable, txEnable, rxEnable;
    logic ackEnable, errFrameEnable, errCountClear, errCountHold, loopbackRoute, rxPinGpio;
    logic txPinGpio, busTransmitPin, storeZero, storeOne, busActive, bitTick, rxBit;
    int fail_count, n_compared;
    typedef struct packed {logic [7:0] req; logic [2:0] st; logic pin; logic ack;} cmc_row_t;
    cmc_row_t rows[4] = '{'{8'h60, 3'h3, 1'b1, 1'b0}, '{8'h40, 3'h2, 1'b1, 1'b0},
        '{8'hE0, 3'h4, 1'b1, 1'b0}, '{8'h00, 3'h0, 1'b0, 1'b1}};
    cmc_mode_ctrl i_dut (.*);
    cmc_bus_node i_node (.mclk(mclk), .reset_n(reset_n), .startFrame(startFrame),
        .busActive(busActive), .bitTick(bitTick), .rxBit(rxBit));
    task chk(input string name, input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task end_sim;
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task wrCtrl(input logic [7:0] d);
        @(posedge mclk);
        ctrlWrite <= 1'b1;
        ctrlWdata <= d;
        @(posedge mclk);
        ctrlWrite <= 1'b0;
    endtask : wrCtrl
    // bounded wait, since a deferred change may take a whole frame
    task waitSt(input logic [2:0] exp);
        #1;
        for (int i = 0; i < 200 && modeStatus !== exp; i++) begin
            @(posedge mclk);
            #1;
        end
        chk("modeStatus", modeStatus, exp);
    endtask : waitSt
    task cfg(input logic [3:0] a, input logic [10:0] d);
        @(posedge mclk);
        cfgWrite <= 1'b1;
        cfgAddr <= a;
        cfgData <= d;
        @(posedge mclk);
        cfgWrite <= 1'b0;
    endtask : cfg
    task frame(input logic [10:0] id, input logic err, input logic [1:0] m, input logic z, o);
        @(posedge mclk);
        frameDone <= 1'b1;
        frameId <= id;
        frameError <= err;
        rxModeOne <= m;
        @(posedge mclk);
        frameDone <= 1'b0;
        #1;
        chk("storeZero", storeZero, z);
        chk("storeOne", storeOne, o);
    endtask : frame
    task timing(input logic exp);
        @(posedge mclk);
        timingWrite <= 1'b1;
        #1;
        chk("timingWriteEn", timingWriteEn, exp);
        @(posedge mclk);
        timingWrite <= 1'b0;
    endtask : timing
    task pulseFrame;
        @(posedge mclk);
        startFrame <= 1'b1;
        @(posedge mclk);
        startFrame <= 1'b0;
    endtask : pulseFrame
    // clock at 125 MHz
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // watchdog cuts a hang short
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    // main sequence
    initial begin
        {reset_n, ctrlWrite, txPending, engineTxLevel, cfgWrite, timingWrite} = '0;
        {wakeupDisable, wakeupIrqEnable, wakeupFlagClear, frameDone, frameError} = '0;
        {startFrame, ctrlWdata, cfgAddr, cfgData, frameId, rxModeZero, rxModeOne} = '0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        chk("modeStatus", modeStatus, MODE_RESET);
        chk("funcMode", funcMode, FUNC_LEGACY);
        cfg(CFG_MASK0, 11'h7FF);
        cfg(CFG_FILT0, 11'h123);
        cfg(CFG_MASK1, 11'h7FF);
        cfg(CFG_FILT0 + 4'h2, 11'h055);
        timing(1'b1);
        foreach (rows[i]) begin
            wrCtrl(rows[i].req);
            waitSt(rows[i].st);
            chk("busTransmitPin", busTransmitPin, rows[i].pin);
            chk("ackEnable", ackEnable, rows[i].ack);
        end
        timing(1'b0);
        cfg(CFG_FILT0 + 4'h2, 11'h0AA);
        frame(11'h123, 1'b0, 2'h0, 1'b1, 1'b0);
        frame(11'h055, 1'b0, 2'h0, 1'b0, 1'b1);
        frame(11'h0AA, 1'b0, 2'h0, 1'b0, 1'b0);
        frame(11'h055, 1'b1, 2'h0, 1'b0, 1'b0);
        frame(11'h055, 1'b1, RXMODE_ERRREC, 1'b0, 1'b1);
        @(posedge mclk);
        txPending <= 1'b1;
        wrCtrl(8'h60);
        repeat (4) @(posedge mclk);
        #1;
        chk("modeStatus", modeStatus, MODE_NORMAL);
        @(posedge mclk);
        txPending <= 1'b0;
        waitSt(MODE_LISTEN);
        wrCtrl(8'h00);
        waitSt(MODE_NORMAL);
        pulseFrame();
        wrCtrl(8'h80);
        repeat (4) @(posedge mclk);
        #1;
        chk("modeStatus", modeStatus, MODE_NORMAL);
        waitSt(MODE_CONFIG);
        chk("errCountClear", errCountClear, 1'b1);
        wrCtrl(8'h00);
        waitSt(MODE_NORMAL);
        pulseFrame();
        wrCtrl(8'h20);
        repeat (4) @(posedge mclk);
        #1;
        chk("modeStatus", modeStatus, MODE_NORMAL);
        waitSt(MODE_SLEEP);
        chk("clockEnable", clockEnable, 1'b0);
        chk("busTransmitPin", busTransmitPin, 1'b1);
        @(posedge mclk);
        wakeupIrqEnable <= 1'b1;
        pulseFrame();
        repeat (2) @(posedge mclk);
        #1;
        chk("wakeIrq", wakeIrq, 1'b1);
        waitSt(MODE_NORMAL);
        frame(11'h055, 1'b0, 2'h0, 1'b0, 1'b0);
        end_sim();
    end
endmodule : testbench
